//--- pin_ctrl_top.sv
`timescale 1ns/10ps
module pin_ctrl_top (
  input wire logic clock_i, // Bus clock, 20 MHz
  input wire logic resetn_i, // Synchronous reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [3:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [7:0] periph_oe_i, // Shared peripheral drives pin
  input wire logic [7:0] analog_en_i, // Analog function owns pin
  output logic [7:0] pin_direction_bits_o, // Port direction, 1 output
  output logic [7:0] pullup_on_o, // Pull-up device enables
  output logic [7:0] pulldown_on_o, // Pull-down device enables
  output logic [7:0] slew_on_o // Slew limiting enables
);

  //==============================================================
  // Bus slave
  pin_ctrl_pkg::bus_state_t state_r;
  pin_ctrl_pkg::bus_state_t state_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic take;
  logic wr_lane0;
  logic wr_pe;
  logic wr_pd;
  logic wr_sl;
  logic wr_dir;
  logic [7:0] pull_enable_bits;
  logic [7:0] pull_direction_bits;
  logic [7:0] slew_limit_bits;
  logic [7:0] pin_direction_bits;
  logic [7:0] out_en;

  // One wait cycle: request taken in idle, ack the next cycle
  assign take = wb_cyc_i & wb_stb_i & (state_r == pin_ctrl_pkg::BUS_IDLE);
  assign wr_lane0 = take & wb_we_i & wb_sel_i[0];
  assign wr_pe = wr_lane0 & (wb_adr_i == pin_ctrl_pkg::PULL_ENABLE_OFF);
  assign wr_pd = wr_lane0 & (wb_adr_i == pin_ctrl_pkg::PULL_DIRECTION_OFF);
  assign wr_sl = wr_lane0 & (wb_adr_i == pin_ctrl_pkg::SLEW_LIMIT_OFF);
  assign wr_dir = wr_lane0 & (wb_adr_i == pin_ctrl_pkg::PIN_DIRECTION_OFF);

  // Read mux; unmapped addresses read zero and still ack
  always_comb
  begin
    state_nxt = pin_ctrl_pkg::BUS_IDLE;
    rdata_nxt = rdata_r;
    if (take)
    begin
      state_nxt = pin_ctrl_pkg::BUS_ACK;
      case (wb_adr_i)
        pin_ctrl_pkg::PULL_ENABLE_OFF: rdata_nxt = {24'h000000, pull_enable_bits};
        pin_ctrl_pkg::PULL_DIRECTION_OFF: rdata_nxt = {24'h000000, pull_direction_bits};
        pin_ctrl_pkg::SLEW_LIMIT_OFF: rdata_nxt = {24'h000000, slew_limit_bits};
        pin_ctrl_pkg::PIN_DIRECTION_OFF: rdata_nxt = {24'h000000, pin_direction_bits};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      state_r <= pin_ctrl_pkg::BUS_IDLE;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      state_r <= state_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign wb_ack_o = (state_r == pin_ctrl_pkg::BUS_ACK);
  assign wb_dat_o = rdata_r;

  //==============================================================
  // Control registers
  // pull enable reset
  pin_ctrl_reg #(
    .MASK(pin_ctrl_pkg::PULL_ENABLE_MASK),
    .RST(pin_ctrl_pkg::PULL_ENABLE_RST)
  ) u_pull_enable (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .wr_i(wr_pe),
    .wdata_i(wb_dat_i[7:0]),
    .q_o(pull_enable_bits)
  );

  pin_ctrl_reg #(
    .MASK(pin_ctrl_pkg::PULL_DIRECTION_MASK),
    .RST(pin_ctrl_pkg::PULL_DIRECTION_RST)
  ) u_pull_direction (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .wr_i(wr_pd),
    .wdata_i(wb_dat_i[7:0]),
    .q_o(pull_direction_bits)
  );

  pin_ctrl_reg #(
    .MASK(pin_ctrl_pkg::SLEW_LIMIT_MASK),
    .RST(pin_ctrl_pkg::SLEW_LIMIT_RST)
  ) u_slew_limit (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .wr_i(wr_sl),
    .wdata_i(wb_dat_i[7:0]),
    .q_o(slew_limit_bits)
  );

  pin_ctrl_reg #(
    .MASK(pin_ctrl_pkg::PIN_DIRECTION_MASK),
    .RST(pin_ctrl_pkg::PIN_DIRECTION_RST)
  ) u_pin_direction (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .wr_i(wr_dir),
    .wdata_i(wb_dat_i[7:0]),
    .q_o(pin_direction_bits)
  );

  assign pin_direction_bits_o = pin_direction_bits;

  //==============================================================
  // Pad control per pin
  // either source drives pin
  assign out_en = pin_direction_bits | periph_oe_i;

  genvar g;
  generate
    for (g = 0; g < pin_ctrl_pkg::PIN_COUNT; g++)
    begin : g_pin
      pin_pad_ctrl u_pad (
        .pull_en_i(pull_enable_bits[g]),
        .pull_dn_i(pull_direction_bits[g]),
        .slew_i(slew_limit_bits[g]),
        .out_en_i(out_en[g]),
        .analog_i(analog_en_i[g]),
        .pullup_on_o(pullup_on_o[g]),
        .pulldown_on_o(pulldown_on_o[g]),
        .slew_on_o(slew_on_o[g])
      );
    end
  endgenerate

endmodule : pin_ctrl_top

//--- pin_ctrl_pkg.sv
//==============================================================
// Summary of operation
// - One pull-enable bit per pin; 1 requests the pull device.
// - Pull forced off when pin driven by port or peripheral output.
// - Pull forced off when an analog function owns the pin.
// - Pull-direction bit on pins 5,4,2..0; 0 pull-up, 1 pull-down.
// - Direction bit only selects; no pull without pull-enable set.
// - Slew-limit bit on pins 5..3,1..0 rate-limits output edges.
// - Slew-limit bit ignored while the pin is an input.
// - After reset every pin is an input, direction bit 0.
// - After reset all pull-enable bits are clear.
package pin_ctrl_pkg;

  //==============================================================
  // Port geometry
  localparam int unsigned PIN_COUNT = 8;

  //==============================================================
  // Register offsets (byte addresses, word aligned)
  localparam logic [3:0] PULL_ENABLE_OFF = 4'h0;
  localparam logic [3:0] PULL_DIRECTION_OFF = 4'h4;
  localparam logic [3:0] SLEW_LIMIT_OFF = 4'h8;
  localparam logic [3:0] PIN_DIRECTION_OFF = 4'hc;

  //==============================================================
  // Implemented bit masks
  localparam logic [7:0] PULL_ENABLE_MASK = 8'hff;
  localparam logic [7:0] PULL_DIRECTION_MASK = 8'h37;
  localparam logic [7:0] SLEW_LIMIT_MASK = 8'h3b;
  localparam logic [7:0] PIN_DIRECTION_MASK = 8'hff;

  //==============================================================
  // Reset values
  localparam logic [7:0] PULL_ENABLE_RST = 8'h00;
  localparam logic [7:0] PULL_DIRECTION_RST = 8'h00;
  localparam logic [7:0] SLEW_LIMIT_RST = 8'h00;
  localparam logic [7:0] PIN_DIRECTION_RST = 8'h00;

  //==============================================================
  // Bus answer state
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage : pin_ctrl_pkg

//--- pin_ctrl_reg.sv
`timescale 1ns/10ps
// One masked 8-bit control register with byte-lane write
module pin_ctrl_reg #(
  parameter logic [7:0] MASK = 8'hff,
  parameter logic [7:0] RST = 8'h00
) (
  input wire logic clock_i, // Bus clock
  input wire logic resetn_i, // Synchronous reset, active low
  input wire logic wr_i, // Write strobe for this register
  input wire logic [7:0] wdata_i, // Write data, lane 0
  output logic [7:0] q_o // Stored value
);

  logic [7:0] val_r;
  logic [7:0] val_nxt;

  // Unimplemented positions never store a one, so they read back 0
  always_comb
  begin
    val_nxt = val_r;
    if (wr_i)
    begin
      val_nxt = wdata_i & MASK;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      val_r <= RST;
    end
    else
    begin
      val_r <= val_nxt;
    end
  end

  assign q_o = val_r;

endmodule : pin_ctrl_reg

//--- pin_pad_ctrl.sv
`timescale 1ns/10ps
// Per-pin pad control: pull gating and slew enable
module pin_pad_ctrl (
  input wire logic pull_en_i, // Pull-enable bit
  input wire logic pull_dn_i, // Pull-direction bit
  input wire logic slew_i, // Slew-limit bit
  input wire logic out_en_i, // Pin driven as output (port or peripheral)
  input wire logic analog_i, // Analog function owns the pin
  output logic pullup_on_o, // Pull-up device on
  output logic pulldown_on_o, // Pull-down device on
  output logic slew_on_o // Slew limiting active
);

  logic pull_on;

  assign pull_on = pull_en_i & ~out_en_i & ~analog_i;
  assign pullup_on_o = pull_on & ~pull_dn_i;
  assign pulldown_on_o = pull_on & pull_dn_i;
  assign slew_on_o = slew_i & out_en_i;

endmodule : pin_pad_ctrl

//--- pad_side_model.sv
`timescale 1ns/10ps
//==========================================
// Peripheral and analog owners of the pins
module pad_side_model (
  input wire logic clock_i, // Bus clock
  input wire logic [7:0] oe_req_i, // Peripheral wants to drive pin
  input wire logic [7:0] an_req_i, // Analog function wants pin
  output logic [7:0] periph_oe_o, // Peripheral output enables
  output logic [7:0] analog_en_o // Analog ownership
);
  logic [7:0] oe_nxt;
  logic [7:0] an_nxt;
  // Owners switch on a clock edge, as on-chip logic would
  always_comb
  begin
    oe_nxt = oe_req_i;
    an_nxt = an_req_i;
  end
  always_ff @(posedge clock_i)
  begin
    periph_oe_o <= oe_nxt;
    analog_en_o <= an_nxt;
  end
endmodule : pad_side_model

//--- pin_ctrl_checker.sv
`timescale 1ns/10ps
//==========================================
// Port-level checks of bus and pad gating
module pin_ctrl_checker (
  input wire logic clock_i, // Bus clock
  input wire logic resetn_i, // Reset, active low
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_ack_o, // Acknowledge
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic [7:0] periph_oe_i, // Peripheral drives
  input wire logic [7:0] analog_en_i, // Analog owns
  input wire logic [7:0] pin_direction_bits_o, // Direction
  input wire logic [7:0] pullup_on_o, // Pull-ups
  input wire logic [7:0] pulldown_on_o, // Pull-downs
  input wire logic [7:0] slew_on_o // Slew enables
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  AST_PULL_OUT: assert property (((pullup_on_o | pulldown_on_o) &
    (pin_direction_bits_o | periph_oe_i)) == 8'h00) else $error("pull on driven pin");
  AST_PULL_ANA: assert property (((pullup_on_o | pulldown_on_o) & analog_en_i) == 8'h00)
    else $error("pull on analog pin");
  AST_PULL_ONE: assert property ((pullup_on_o & pulldown_on_o) == 8'h00)
    else $error("both pulls on");
  AST_PD_MASK: assert property ((pulldown_on_o & 8'hc8) == 8'h00)
    else $error("pull-down on pin without select");
  AST_SLEW_MASK: assert property ((slew_on_o & 8'hc4) == 8'h00)
    else $error("slew on pin without control");
  AST_SLEW_IN: assert property ((slew_on_o & ~(pin_direction_bits_o | periph_oe_i)) == 8'h00)
    else $error("slew on input pin");
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one-cycle answer");
  AST_RST: assert property (disable iff (1'b0) !resetn_i |=> pin_direction_bits_o == 8'h00
    && pullup_on_o == 8'h00 && pulldown_on_o == 8'h00) else $error("pins not idle after reset");
  AST_HI_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule : pin_ctrl_checker

//--- tb.sv
`timescale 1ns/10ps
module tb;
  logic clock_i = 0, resetn_i = 0, cyc = 0, stb = 0, we = 0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic [7:0] oe_req = 8'h00, an_req = 8'h00, oe, an, dir, pu, pd, sl;
  logic ack;
  int errors = 0, cmp_count = 0;
  pad_side_model i_pads (.clock_i(clock_i), .oe_req_i(oe_req), .an_req_i(an_req),
    .periph_oe_o(oe), .analog_en_o(an));
  pin_ctrl_top i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .periph_oe_i(oe), .analog_en_i(an), .pin_direction_bits_o(dir),
    .pullup_on_o(pu), .pulldown_on_o(pd), .slew_on_o(sl));
  initial forever #25 clock_i = ~clock_i;
  //==========================================
  // Checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Holds the request until ack is sampled; bounded so a dead slave cannot hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'h1; wdat <= {24'h0, d};
    do
    begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 0; stb <= 0;
    if (n >= 20) chk("ack", 1, 0);
  endtask : bus
  task automatic pads(input logic [7:0] eu, input logic [7:0] ed, input logic [7:0] es);
    repeat (2) @(posedge clock_i);
    chk("pullup", eu, pu);
    chk("pulldown", ed, pd);
    chk("slew", es, sl);
  endtask : pads
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (2000) @(posedge clock_i);
    errors++;
    give_verdict;
  end
  //==========================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clock_i);
    resetn_i <= 1;
    // Reset values of all four registers
    for (int i = 0; i < 4; i++)
    begin
      bus(0, 4'(i * 4), 8'h00);
      chk("reset value", 0, rd);
    end
    pads(8'h00, 8'h00, 8'h00);
    chk("direction out", 0, dir);
    // Write all ones; unimplemented bits must read back 0
    for (int i = 0; i < 3; i++)
    begin
      bus(1, 4'(i * 4), 8'hff);
      bus(0, 4'(i * 4), 8'h00);
      chk("masked", i == 0 ? 8'hff : (i == 1 ? 8'h37 : 8'h3b), rd);
    end
    pads(8'hc8, 8'h37, 8'h00);
    oe_req <= 8'h03;
    an_req <= 8'h30;
    pads(8'hc8, 8'h04, 8'h03);
    bus(1, 4'hc, 8'hc0);
    chk("direction out", 8'hc0, dir);
    pads(8'h08, 8'h04, 8'h03);
    bus(1, 4'h0, 8'h00);
    pads(8'h00, 8'h00, 8'h03);
    // Unmapped address: write dropped, read returns zero
    bus(1, 4'h2, 8'hff);
    bus(0, 4'h2, 8'h00);
    chk("unmapped read", 0, rd);
    bus(0, 4'h0, 8'h00);
    chk("pull enable kept", 0, rd);
    // Reset in mid-run must clear port direction, pulls and slew on every pin
    bus(1, 4'h0, 8'hff);
    pads(8'h08, 8'h04, 8'h03);
    resetn_i <= 0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1;
    pads(8'h00, 8'h00, 8'h00);
    chk("direction after reset", 0, dir);
    bus(0, 4'h8, 8'h00);
    chk("slew after reset", 0, rd);
    give_verdict;
  end
endmodule : tb
bind pin_ctrl_top pin_ctrl_checker i_chk (.clock_i(clock_i), .resetn_i(resetn_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .periph_oe_i(periph_oe_i), .analog_en_i(analog_en_i),
  .pin_direction_bits_o(pin_direction_bits_o), .pullup_on_o(pullup_on_o),
  .pulldown_on_o(pulldown_on_o), .slew_on_o(slew_on_o));
